// >>> shared/bfs_pkg.sv
// Package of constants shared by the fault signalling block.
package bfs_pkg;
  // ---------------------------------------------------------------
  // Clock and timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
  localparam int unsigned NMI_PULSE_MS = 30;
  localparam int unsigned QUIET_MINUTES = 30;
  localparam int unsigned QUIET_MS = QUIET_MINUTES * 60 * 1000;
  localparam int unsigned BEEP_ON_MS = 250;
  localparam int unsigned BEEP_GAP_MS = 250;
  localparam int unsigned DIGIT_GAP_MS = 1000;
  localparam int unsigned MAX_WDT_RESETS = 3;

  // ---------------------------------------------------------------
  // Beep codes, four digits of four bits each, first digit highest
  // ---------------------------------------------------------------
  localparam logic [15:0] CODE_CPU_MISSING = 16'h1521;
  localparam logic [15:0] CODE_CFG_MISMATCH = 16'h1524;
  localparam logic [15:0] CODE_PGOOD_DROP = 16'h1542;
  localparam logic [15:0] CODE_PGOOD_TIMEOUT = 16'h1544;
  localparam logic [15:0] CODE_VR_WDT = 16'h1512;
  localparam logic [15:0] CODE_PSU_MISMATCH = 16'h1514;
  localparam int unsigned CODE_DIGITS = 4;
  localparam int unsigned DIGIT_W = 4;

  // Number of failure sources in the beep request vector.
  localparam int unsigned SRC_COUNT = 6;

  // Beep sequencer states.
  typedef enum logic [2:0] {
    BFS_BEEP_IDLE,
    BFS_BEEP_ON,
    BFS_BEEP_GAP,
    BFS_BEEP_DIGIT_GAP
  } bfs_beep_e;
endpackage

// >>> hdl/bfs_beeper.sv
// Beep code sequencer that sounds one four-digit code on request.
`timescale 1ns/1ns
module bfs_beeper #(
  parameter int unsigned CYC_PER_MS = bfs_pkg::CYC_PER_MS
) (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic start_in,
  input wire logic [15:0] code_in,
  output logic busy_out,
  output logic beep_out
);
  localparam int unsigned ON_CYC = bfs_pkg::BEEP_ON_MS * CYC_PER_MS;
  localparam int unsigned GAP_CYC = bfs_pkg::BEEP_GAP_MS * CYC_PER_MS;
  localparam int unsigned DGAP_CYC = bfs_pkg::DIGIT_GAP_MS * CYC_PER_MS;

  bfs_pkg::bfs_beep_e state_q;
  logic [15:0] code_q;
  logic [3:0] left_q;
  logic [2:0] digit_q;
  logic [31:0] tmr_q;

  // Current digit taken from the top nibble of the shifting code.
  function automatic logic [3:0] top_digit(input logic [15:0] c);
    top_digit = c[15:12];
  endfunction

  // ---------------------------------------------------------------
  // Sequencer: each digit is a burst of beeps equal to its value.
  // ---------------------------------------------------------------
  // A digit of zero yields no beeps, only a silent gap: one beep length for the first digit, the inter-digit gap otherwise.
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      state_q <= bfs_pkg::BFS_BEEP_IDLE;
      code_q <= 16'h0000;
      left_q <= 4'h0;
      digit_q <= 3'h0;
      tmr_q <= 32'h0000_0000;
      beep_out <= 1'b0;
      busy_out <= 1'b0;
    end else if (ce_in) begin
      unique case (state_q)
        bfs_pkg::BFS_BEEP_IDLE: begin
          if (start_in) begin
            code_q <= code_in;
            left_q <= top_digit(code_in);
            digit_q <= 3'(bfs_pkg::CODE_DIGITS - 1);
            tmr_q <= 32'(ON_CYC - 1);
            beep_out <= (top_digit(code_in) != 4'h0);
            busy_out <= 1'b1;
            state_q <= (top_digit(code_in) != 4'h0) ? bfs_pkg::BFS_BEEP_ON
                                                     : bfs_pkg::BFS_BEEP_DIGIT_GAP;
          end
        end
        bfs_pkg::BFS_BEEP_ON: begin
          if (tmr_q == 32'h0000_0000) begin
            beep_out <= 1'b0;
            left_q <= left_q - 4'h1;
            if (left_q == 4'h1) begin
              tmr_q <= 32'(DGAP_CYC - 1);
              state_q <= bfs_pkg::BFS_BEEP_DIGIT_GAP;
            end else begin
              tmr_q <= 32'(GAP_CYC - 1);
              state_q <= bfs_pkg::BFS_BEEP_GAP;
            end
          end else begin
            tmr_q <= tmr_q - 32'h0000_0001;
          end
        end
        bfs_pkg::BFS_BEEP_GAP: begin
          if (tmr_q == 32'h0000_0000) begin
            beep_out <= 1'b1;
            tmr_q <= 32'(ON_CYC - 1);
            state_q <= bfs_pkg::BFS_BEEP_ON;
          end else begin
            tmr_q <= tmr_q - 32'h0000_0001;
          end
        end
        bfs_pkg::BFS_BEEP_DIGIT_GAP: begin
          if (tmr_q != 32'h0000_0000) begin
            tmr_q <= tmr_q - 32'h0000_0001;
          end else if (digit_q == 3'h0) begin
            busy_out <= 1'b0;
            state_q <= bfs_pkg::BFS_BEEP_IDLE;
          end else begin
            digit_q <= digit_q - 3'h1;
            code_q <= {code_q[11:0], 4'h0};
            left_q <= code_q[11:8];
            if (code_q[11:8] != 4'h0) begin
              beep_out <= 1'b1;
              tmr_q <= 32'(ON_CYC - 1);
              state_q <= bfs_pkg::BFS_BEEP_ON;
            end else begin
              tmr_q <= 32'(DGAP_CYC - 1);
            end
          end
        end
        default: begin
          state_q <= bfs_pkg::BFS_BEEP_IDLE;
        end
      endcase
    end
  end
endmodule

// >>> hdl/bfs_fault_signaling.sv
// Fault signalling top: diagnostic interrupt, beep codes, reset limiter.
`timescale 1ns/1ns
module bfs_fault_signaling #(
  parameter int unsigned CYC_PER_MS = bfs_pkg::CYC_PER_MS,
  parameter int unsigned QUIET_MS = bfs_pkg::QUIET_MS,
  parameter int unsigned MAX_RESETS = bfs_pkg::MAX_WDT_RESETS
) (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic host_reset_in,
  input wire logic host_power_down_in,
  input wire logic chassis_nmi_req_in,
  input wire logic pretimeout_in,
  input wire logic pretimeout_nmi_sel_in,
  input wire logic fp_button_in,
  input wire logic wdt_reset_in,
  input wire logic cpu_missing_in,
  input wire logic cfg_mismatch_in,
  input wire logic pgood_drop_in,
  input wire logic pgood_timeout_in,
  input wire logic vr_wdt_in,
  input wire logic psu_mismatch_in,
  output logic nmi_out,
  output logic nmi_lockout_out,
  output logic diag_event_out,
  output logic wdt_event_out,
  output logic stay_boot_loader_out,
  output logic [1:0] wdt_count_out,
  output logic front_status_lamp_degraded_out,
  output logic beep_out,
  output logic beep_busy_out
);
  // ---------------------------------------------------------------
  // Derived counts
  // ---------------------------------------------------------------
  localparam int unsigned NMI_CYC = bfs_pkg::NMI_PULSE_MS * CYC_PER_MS;

  logic ms_tick_q;
  logic [31:0] ms_div_q;
  logic [31:0] nmi_tmr_q;
  logic [31:0] quiet_ms_q;
  logic nmi_trigger;
  logic host_clear;
  logic [bfs_pkg::SRC_COUNT-1:0] src_now;
  logic [bfs_pkg::SRC_COUNT-1:0] src_prev_q;
  logic [bfs_pkg::SRC_COUNT-1:0] pend_q;
  logic beep_start_q;
  logic [15:0] beep_code_q;
  logic beeper_busy;
  logic beeper_beep;

  // Saturating increment used by the quiet timer.
  function automatic logic [31:0] sat_inc(input logic [31:0] v);
    sat_inc = (v == 32'hFFFF_FFFF) ? v : v + 32'h0000_0001;
  endfunction

  // Code table selected by source index.
  function automatic logic [15:0] code_of(input int unsigned idx);
    unique case (idx)
      0: code_of = bfs_pkg::CODE_CPU_MISSING;
      1: code_of = bfs_pkg::CODE_CFG_MISMATCH;
      2: code_of = bfs_pkg::CODE_PGOOD_DROP;
      3: code_of = bfs_pkg::CODE_PGOOD_TIMEOUT;
      4: code_of = bfs_pkg::CODE_VR_WDT;
      default: code_of = bfs_pkg::CODE_PSU_MISMATCH;
    endcase
  endfunction

  assign host_clear = host_reset_in | host_power_down_in;
  assign nmi_trigger = chassis_nmi_req_in | fp_button_in
                     | (pretimeout_in & pretimeout_nmi_sel_in);

  // ---------------------------------------------------------------
  // Millisecond tick
  // ---------------------------------------------------------------
  // The quiet timer counts milliseconds so its counter stays small.
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      ms_div_q <= 32'h0000_0000;
      ms_tick_q <= 1'b0;
    end else if (ce_in) begin
      ms_tick_q <= (ms_div_q == 32'(CYC_PER_MS - 1));
      ms_div_q <= (ms_div_q == 32'(CYC_PER_MS - 1)) ? 32'h0000_0000 : ms_div_q + 32'h0000_0001;
    end
  end

  // ---------------------------------------------------------------
  // Diagnostic interrupt pulse and lockout
  // ---------------------------------------------------------------
  // Requests are not queued: anything arriving while busy or locked is dropped.
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      nmi_out <= 1'b0;
      nmi_lockout_out <= 1'b0;
      nmi_tmr_q <= 32'h0000_0000;
    end else if (ce_in) begin
      if (nmi_out) begin
        if (nmi_tmr_q == 32'h0000_0000) begin
          nmi_out <= 1'b0;
        end else begin
          nmi_tmr_q <= nmi_tmr_q - 32'h0000_0001;
        end
      end else if (host_clear) begin
        nmi_lockout_out <= 1'b0;
      end else if (nmi_trigger && !nmi_lockout_out) begin
        nmi_out <= 1'b1;
        nmi_lockout_out <= 1'b1;
        nmi_tmr_q <= 32'(NMI_CYC - 1);
      end
    end
  end

  // Sensor event only for button and pre-timeout causes, never for chassis control.
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      diag_event_out <= 1'b0;
    end else if (ce_in) begin
      diag_event_out <= !nmi_out && !host_clear && !nmi_lockout_out
                        && (fp_button_in
                            || (pretimeout_in && pretimeout_nmi_sel_in));
    end
  end

  // ---------------------------------------------------------------
  // Watchdog reset limiter
  // ---------------------------------------------------------------
  // rst_in stands for a power cycle of the controller and clears the count.
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      wdt_count_out <= 2'b00;
      quiet_ms_q <= 32'h0000_0000;
      stay_boot_loader_out <= 1'b0;
      wdt_event_out <= 1'b0;
    end else if (ce_in) begin
      wdt_event_out <= wdt_reset_in && !stay_boot_loader_out;
      if (stay_boot_loader_out) begin
        quiet_ms_q <= 32'h0000_0000;
      end else if (wdt_reset_in) begin
        quiet_ms_q <= 32'h0000_0000;
        if (32'(wdt_count_out) + 32'h0000_0001 >= 32'(MAX_RESETS)) begin
          stay_boot_loader_out <= 1'b1;
        end
        wdt_count_out <= wdt_count_out + 2'b01;
      end else if (ms_tick_q) begin
        if (quiet_ms_q >= 32'(QUIET_MS)) begin
          wdt_count_out <= 2'b00;
        end else begin
          quiet_ms_q <= sat_inc(quiet_ms_q);
        end
      end
    end
  end

  // Degraded lamp: the set wins over a host reset in the same cycle.
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      front_status_lamp_degraded_out <= 1'b0;
    end else if (ce_in) begin
      if (wdt_reset_in && !stay_boot_loader_out) begin
        front_status_lamp_degraded_out <= 1'b1;
      end else if (host_clear) begin
        front_status_lamp_degraded_out <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Beep code requests
  // ---------------------------------------------------------------
  assign src_now = {psu_mismatch_in, vr_wdt_in, pgood_timeout_in,
                    pgood_drop_in, cfg_mismatch_in, cpu_missing_in};

  // Each rising edge of a failure latches one pending code; a held level
  // does not retrigger, so a code never repeats continuously.
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      src_prev_q <= '0;
      pend_q <= '0;
      beep_start_q <= 1'b0;
      beep_code_q <= 16'h0000;
    end else if (ce_in) begin
      logic [bfs_pkg::SRC_COUNT-1:0] p;
      logic found;
      p = pend_q | (src_now & ~src_prev_q);
      found = 1'b0;
      src_prev_q <= src_now;
      beep_start_q <= 1'b0;
      if (!beeper_busy && !beep_start_q) begin
        for (int unsigned i = 0; i < bfs_pkg::SRC_COUNT; i++) begin
          if (p[i] && !found) begin
            found = 1'b1;
            p[i] = 1'b0;
            beep_code_q <= code_of(i);
          end
        end
        beep_start_q <= found;
      end
      pend_q <= p;
    end
  end

  bfs_beeper #(
    .CYC_PER_MS(CYC_PER_MS)
  ) u_beeper (
    .clk_sys_in(clk_sys_in),
    .rst_in(rst_in),
    .ce_in(ce_in),
    .start_in(beep_start_q),
    .code_in(beep_code_q),
    .busy_out(beeper_busy),
    .beep_out(beeper_beep)
  );

  // Registered copies keep the top outputs straight from flip-flops.
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      beep_out <= 1'b0;
      beep_busy_out <= 1'b0;
    end else if (ce_in) begin
      beep_out <= beeper_beep;
      beep_busy_out <= beeper_busy | beep_start_q | (|pend_q);
    end
  end
endmodule

// >>> testbench/bfs_monitor.sv
// Concurrent checks on the fault signalling block's ports.
`timescale 1ns/1ns
module bfs_monitor #(
  parameter int unsigned CYC_PER_MS = bfs_pkg::CYC_PER_MS,
  parameter int unsigned QUIET_MS = bfs_pkg::QUIET_MS,
  parameter int unsigned MAX_RESETS = bfs_pkg::MAX_WDT_RESETS
) (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic host_reset_in,
  input wire logic host_power_down_in,
  input wire logic chassis_nmi_req_in,
  input wire logic pretimeout_in,
  input wire logic pretimeout_nmi_sel_in,
  input wire logic fp_button_in,
  input wire logic wdt_reset_in,
  input wire logic nmi_out,
  input wire logic nmi_lockout_out,
  input wire logic diag_event_out,
  input wire logic wdt_event_out,
  input wire logic stay_boot_loader_out,
  input wire logic [1:0] wdt_count_out,
  input wire logic front_status_lamp_degraded_out,
  input wire logic beep_out,
  input wire logic beep_busy_out
);
  localparam int NMI_CYC = bfs_pkg::NMI_PULSE_MS * CYC_PER_MS;
  logic clr_w;
  logic take_w;
  logic diag_w;
  int hi_q;
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (rst_in);
  // A request counts only while no pulse, lockout or host clear stands in its way.
  assign clr_w = host_reset_in || host_power_down_in;
  assign take_w = ce_in && !nmi_out && !nmi_lockout_out && !clr_w;
  assign diag_w = fp_button_in || (pretimeout_in && pretimeout_nmi_sel_in);
  // Length of the running pulse, judged at its falling edge.
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      hi_q <= 0;
    end else begin
      hi_q <= nmi_out ? hi_q + 1 : 0;
    end
  end
  nmi_width_a: assert property ($fell(nmi_out) |-> hi_q == NMI_CYC)
    else $error("interrupt pulse width wrong");
  one_pulse_a: assert property ($rose(nmi_out) |-> !$past(nmi_lockout_out))
    else $error("pulse during lockout");
  has_cause_a: assert property ($rose(nmi_out) |-> $past(chassis_nmi_req_in || diag_w))
    else $error("pulse without fresh request");
  quiet_cmd_a: assert property (take_w && chassis_nmi_req_in && !diag_w |=> nmi_out && !diag_event_out)
    else $error("command pulse wrong");
  logged_a: assert property (take_w && diag_w |=> nmi_out && diag_event_out)
    else $error("logged pulse wrong");
  diag_new_a: assert property (diag_event_out |-> $rose(nmi_out))
    else $error("event without new pulse");
  wdt_step_a: assert property (ce_in && wdt_reset_in && !stay_boot_loader_out |=>
    wdt_event_out && front_status_lamp_degraded_out && wdt_count_out == $past(wdt_count_out) + 2'd1)
    else $error("watchdog reset not recorded");
  limit_a: assert property (stay_boot_loader_out |-> wdt_count_out == 2'(MAX_RESETS))
    else $error("boot loader latch without full count");
  after_limit_a: assert property (stay_boot_loader_out && wdt_reset_in |=> !wdt_event_out)
    else $error("reset taken past limit");
  lamp_hold_a: assert property (front_status_lamp_degraded_out && !clr_w |=>
    front_status_lamp_degraded_out)
    else $error("lamp dropped without host clear");
  beep_busy_a: assert property (beep_out |-> beep_busy_out)
    else $error("tone while idle");
  cover property ($rose(nmi_out) && diag_event_out);
  cover property ($rose(stay_boot_loader_out));
  cover property ($fell(beep_busy_out));
endmodule

bind bfs_fault_signaling bfs_monitor #(.CYC_PER_MS(CYC_PER_MS), .QUIET_MS(QUIET_MS),
  .MAX_RESETS(MAX_RESETS)) u_mon (.clk_sys_in, .rst_in, .ce_in, .host_reset_in,
  .host_power_down_in, .chassis_nmi_req_in, .pretimeout_in, .pretimeout_nmi_sel_in,
  .fp_button_in, .wdt_reset_in, .nmi_out, .nmi_lockout_out, .diag_event_out, .wdt_event_out,
  .stay_boot_loader_out, .wdt_count_out, .front_status_lamp_degraded_out, .beep_out,
  .beep_busy_out);

// >>> testbench/bfs_host_model.sv
// Host and front panel model: button, host reset and interrupt pulse meter.
`timescale 1ns/1ns
module bfs_host_model (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic nmi_in,
  input wire logic press_in,
  input wire logic clear_in,
  output logic fp_button_out,
  output logic host_reset_out,
  output int width_out,
  output int pulses_out
);
  int run_q;
  // Button and host reset follow the bench, which changes them off the clock edge.
  assign fp_button_out = press_in;
  assign host_reset_out = clear_in;
  // Measure pulses as sampled at rising clock edges; a glitch between edges would not count as a pulse.
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      run_q <= 0;
      width_out <= 0;
      pulses_out <= 0;
    end else if (nmi_in) begin
      run_q <= run_q + 1;
      pulses_out <= (run_q == 0) ? pulses_out + 1 : pulses_out;
    end else begin
      width_out <= (run_q != 0) ? run_q : width_out;
      run_q <= 0;
    end
  end
endmodule

// >>> testbench/test_bfs_fault_signaling.sv
// Self-checking bench for the fault signalling block.
`timescale 1ns/1ns
module test_bfs_fault_signaling;
  localparam int CPM = 1;
  localparam int QMS = 20;
  localparam int NMI_CYC = bfs_pkg::NMI_PULSE_MS * CPM;
  localparam int CHS = 0, PRE = 1, BTN = 2, CLR = 3, WDT = 4, PDN = 5;
  localparam logic [15:0] CODES [6] = '{bfs_pkg::CODE_CPU_MISSING, bfs_pkg::CODE_CFG_MISMATCH,
    bfs_pkg::CODE_PGOOD_DROP, bfs_pkg::CODE_PGOOD_TIMEOUT, bfs_pkg::CODE_VR_WDT,
    bfs_pkg::CODE_PSU_MISMATCH};
  logic clk_sys_in, rst_in, host_reset_in, fp_button_in, sel, nmi_out, nmi_lockout_out;
  logic diag_event_out, wdt_event_out, stay_boot_loader_out, lamp, beep_out, beep_busy_out;
  logic [1:0] wdt_count_out;
  logic ce;
  logic [5:0] st, lvl;
  int fails, checks, width, pulses, cyc;
  bfs_fault_signaling #(.CYC_PER_MS(CPM), .QUIET_MS(QMS), .MAX_RESETS(3)) u_dut (
    .clk_sys_in, .rst_in, .ce_in(ce), .host_reset_in, .host_power_down_in(st[PDN]),
    .chassis_nmi_req_in(st[CHS]), .pretimeout_in(st[PRE]), .pretimeout_nmi_sel_in(sel),
    .fp_button_in, .wdt_reset_in(st[WDT]), .cpu_missing_in(lvl[0]), .cfg_mismatch_in(lvl[1]),
    .pgood_drop_in(lvl[2]), .pgood_timeout_in(lvl[3]), .vr_wdt_in(lvl[4]),
    .psu_mismatch_in(lvl[5]), .nmi_out, .nmi_lockout_out, .diag_event_out, .wdt_event_out,
    .stay_boot_loader_out, .wdt_count_out, .front_status_lamp_degraded_out(lamp), .beep_out,
    .beep_busy_out);
  bfs_host_model u_host (.clk_sys_in, .rst_in, .nmi_in(nmi_out), .press_in(st[BTN]),
    .clear_in(st[CLR]), .fp_button_out(fp_button_in), .host_reset_out(host_reset_in),
    .width_out(width), .pulses_out(pulses));
  // Free running clock.
  initial begin
    clk_sys_in = 0;
    forever #50 clk_sys_in = ~clk_sys_in;
  end
  // Cut a hung run short; all scenarios need about 55000 cycles.
  always @(posedge clk_sys_in) begin
    cyc++;
    if (cyc == 90000) begin
      fails++;
      report_and_stop();
    end
  end
  task automatic chk(input logic ok, input string msg);
    checks++;
    if (ok !== 1'b1) begin
      fails++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clk_sys_in);
  endtask
  // One-cycle strobe on a chosen request line, raised and dropped at falling edges.
  task automatic fire(input int b);
    st[b] = 1'b1;
    tick(1);
    st[b] = 1'b0;
  endtask
  task automatic report_and_stop();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // Command pulse, requests during the pulse and lockout, then clear by power-down.
  task automatic t_chassis();
    fire(CHS);
    chk(nmi_out === 1'b1 && diag_event_out === 1'b0, "command pulse");
    fire(BTN);
    chk(diag_event_out === 1'b0, "request taken during pulse");
    fire(CLR);
    tick(NMI_CYC);
    chk(nmi_out === 1'b0 && width == NMI_CYC, "pulse width");
    sel = 1'b1;
    fire(PRE);
    chk(nmi_out === 1'b0 && nmi_lockout_out === 1'b1, "second pulse in lockout");
    fire(PDN);
    tick(2);
    chk(nmi_lockout_out === 1'b0 && pulses == 1, "stale request or lockout");
  endtask
  // Pre-timeout without and with the interrupt action, or a button press.
  task automatic t_diag(input logic pre);
    sel = 1'b0;
    fire(PRE);
    chk(nmi_out === 1'b0, "pretimeout without action");
    sel = 1'b1;
    fire(pre ? PRE : BTN);
    chk(nmi_out === 1'b1 && diag_event_out === 1'b1, "logged pulse");
    tick(NMI_CYC + 2);
    fire(CLR);
    tick(1);
    chk(nmi_lockout_out === 1'b0, "lockout after host reset");
  endtask
  // Reset limit, power cycle, quiet period restart and lamp clear.
  task automatic t_wdt();
    for (int i = 1; i <= 4; i++) begin
      fire(WDT);
      chk(wdt_event_out === (i < 4) && wdt_count_out === 2'(i > 3 ? 3 : i), "count");
      chk(lamp === 1'b1 && stay_boot_loader_out === (i > 2), "lamp or limit");
      tick(5);
    end
    tick(QMS + 10);
    chk(wdt_count_out === 2'd3, "count cleared in boot loader");
    rst_in = 1'b1;
    tick(2);
    rst_in = 1'b0;
    tick(1);
    chk(wdt_count_out === 2'd0 && stay_boot_loader_out === 1'b0, "power cycle");
    // A low clock enable must hold every register, even across a reset request.
    ce = 1'b0;
    fire(WDT);
    chk(wdt_count_out === 2'd0 && wdt_event_out === 1'b0, "state moved while frozen");
    ce = 1'b1;
    fire(WDT);
    tick(QMS - 5);
    fire(WDT);
    tick(QMS - 5);
    chk(wdt_count_out === 2'd2, "quiet timer not restarted");
    tick(10);
    chk(wdt_count_out === 2'd0 && lamp === 1'b1, "quiet clear or lamp");
    fire(CLR);
    tick(1);
    chk(lamp === 1'b0, "lamp kept after host reset");
  endtask
  // Every code: count beeps per digit, then see that a held failure stays silent.
  task automatic t_beep();
    int n, low, d;
    logic prev;
    for (int i = 0; i < 6; i++) begin
      lvl[i] = 1'b1;
      n = 0;
      low = 0;
      d = 0;
      prev = 1'b0;
      while (low < 1500) begin
        tick(1);
        if (beep_out === 1'b1 && prev === 1'b0) begin
          if (low > 600) begin
            chk(n == CODES[i][15 - 4 * d -: 4], "digit");
            d++;
            n = 0;
          end
          n++;
          low = 0;
        end else if (beep_out !== 1'b1 && n > 0) begin
          low++;
        end
        prev = beep_out;
      end
      chk(n == CODES[i][3:0] && d == 3, "last digit");
      chk(beep_busy_out === 1'b0, "code repeats");
      lvl[i] = 1'b0;
      tick(2);
    end
  endtask
  // Main sequence.
  initial begin
    rst_in = 1'b1;
    st = '0;
    lvl = '0;
    sel = 1'b0;
    ce = 1'b1;
    tick(5);
    rst_in = 1'b0;
    tick(1);
    t_chassis();
    t_diag(1'b0);
    t_diag(1'b1);
    t_wdt();
    t_beep();
    report_and_stop();
  end
endmodule
